// ### logic/pcr_map.svh
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// Pad configuration register addresses on the slave control port.
`define PCR_ADDR_MASTER_SEL   16'hf79f
`define PCR_ADDR_MASTER_DOUT  16'hf7a0
`define PCR_ADDR_MP_SIX       16'hf7a1
`define PCR_ADDR_MP_SEVEN     16'hf7a2
`define PCR_ADDR_CLOCK_OUT    16'hf7a3
`define PCR_ADDR_SOFT_RESET   16'hf890

// Clock-synthesis register window.
`define PCR_ADDR_SYNTH_FIRST  16'hf000
`define PCR_ADDR_SYNTH_LAST   16'hf006

// Counts of registers.
`define PCR_PAD_COUNT         5
`define PCR_SYNTH_COUNT       7

// Reset values.
`define PCR_RST_PAD_PULLED    16'h0018
`define PCR_RST_PAD_CLOCK     16'h0008
`define PCR_RST_SOFT_RESET    16'h0001
`define PCR_RST_SYNTH         16'h0000

// Field positions inside a pad register.
`define PCR_PULL_BIT          4
`define PCR_EDGE_HI           3
`define PCR_EDGE_LO           2
`define PCR_DRIVE_HI          1
`define PCR_DRIVE_LO          0

// Field position inside the soft reset register.
`define PCR_SOFT_RUN_BIT      0

// Cycles from a taken read to its answer.
`define PCR_RD_LATENCY        2

`endif

// ### logic/pcr_pkg.sv
`default_nettype none

package pcr_pkg;
  `include "pcr_map.svh"

  typedef logic [15:0] pcr_word_t;

  typedef enum logic [1:0] {
    PCR_EDGE_SLOWEST = 2'h0,
    PCR_EDGE_SLOW    = 2'h1,
    PCR_EDGE_FAST    = 2'h2,
    PCR_EDGE_FASTEST = 2'h3
  } pcr_edge_rate_t;

  typedef enum logic [1:0] {
    PCR_DRIVE_LOWEST  = 2'h0,
    PCR_DRIVE_LOW     = 2'h1,
    PCR_DRIVE_HIGH    = 2'h2,
    PCR_DRIVE_HIGHEST = 2'h3
  } pcr_drive_level_t;

  // One pad's settings as presented to the pad cell.
  typedef struct packed {
    logic             pull_en;
    pcr_edge_rate_t   edge_rate;
    pcr_drive_level_t drive_level;
  } pcr_pad_fields_t;

  typedef pcr_pad_fields_t [`PCR_PAD_COUNT-1:0] pcr_pad_bus_t;

  typedef enum logic [1:0] {
    PCR_ST_RUN  = 2'b01,
    PCR_ST_SOFT = 2'b10
  } pcr_state_t;

  // Register access request from the slave control port.
  typedef struct packed {
    logic      wr;
    logic      rd;
    pcr_word_t addr;
    pcr_word_t wdata;
  } pcr_req_t;
endpackage

`default_nettype wire

// ### logic/pcr_synth_regs.sv
`default_nettype none

module pcr_synth_regs
  import pcr_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       wr_en_in,
  input  wire logic [2:0] wr_idx_in,
  input  wire pcr_word_t  wr_data_in,
  input  wire logic       rd_en_in,
  input  wire logic [2:0] rd_idx_in,
  output pcr_word_t       rd_data_out
);

  typedef struct packed {
    pcr_word_t [`PCR_SYNTH_COUNT-1:0] words;
    pcr_word_t                        rd_data;
  } pcr_synth_state_t;

  pcr_synth_state_t state_reg;
  pcr_synth_state_t state_next;
  pcr_word_t [`PCR_SYNTH_COUNT-1:0] word_next_w;

  // Only the hardware reset reaches this storage; soft reset never does.
  genvar gi;
  generate
    for (gi = 0; gi < `PCR_SYNTH_COUNT; gi++) begin : g_word
      assign word_next_w[gi] =
        (wr_en_in && wr_idx_in == 3'(gi)) ? wr_data_in
                                          : state_reg.words[gi];
    end
  endgenerate

  always_comb begin
    state_next       = state_reg;
    state_next.words = word_next_w;
    if (rd_en_in && rd_idx_in < 3'(`PCR_SYNTH_COUNT)) begin
      state_next.rd_data = state_reg.words[rd_idx_in];
    end else begin
      state_next.rd_data = '0;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg.words   <= {`PCR_SYNTH_COUNT{`PCR_RST_SYNTH}};
      state_reg.rd_data <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data_out = state_reg.rd_data;

endmodule

`default_nettype wire

// ### logic/pcr_pad_ctrl.sv
`include "pcr_map.svh"
`default_nettype none

module pcr_pad_ctrl
  import pcr_pkg::*;
(
  input  wire logic      core_clk_in,
  input  wire logic      arst_n_in,
  input  wire logic      reg_wr_in,
  input  wire logic      reg_rd_in,
  input  wire pcr_word_t reg_addr_in,
  input  wire pcr_word_t reg_wdata_in,
  input  wire logic      spi_select_in,
  output pcr_word_t      reg_rdata_out,
  output logic           reg_rd_valid_out,
  output pcr_pad_bus_t   pad_cfg_out,
  output logic           soft_reset_active_out,
  output logic           control_port_spi_out
);

  // Reset value of each pad register, highest address first.
  localparam pcr_word_t [`PCR_PAD_COUNT-1:0] PAD_RESET = {
    `PCR_RST_PAD_CLOCK,
    `PCR_RST_PAD_PULLED,
    `PCR_RST_PAD_PULLED,
    `PCR_RST_PAD_PULLED,
    `PCR_RST_PAD_PULLED
  };

  localparam pcr_word_t PAD_BASE = `PCR_ADDR_MASTER_SEL;
  localparam pcr_word_t PAD_LAST = `PCR_ADDR_CLOCK_OUT;

  // Source of the read answer held between the two read stages.
  typedef enum logic [2:0] {
    PCR_SRC_NONE  = 3'b001,
    PCR_SRC_LOCAL = 3'b010,
    PCR_SRC_SYNTH = 3'b100
  } pcr_rd_src_t;

  typedef struct packed {
    pcr_state_t                        fsm;
    pcr_word_t [`PCR_PAD_COUNT-1:0]    pad;
    pcr_word_t                         soft_word;
    logic                              spi_mode;
    pcr_rd_src_t                       rd_src;
    pcr_word_t                         rd_stage;
    logic                              rd_stage_vld;
    pcr_word_t                         rdata;
    logic                              rd_valid;
    pcr_pad_bus_t                      pad_fields;
  } pcr_ctrl_state_t;

  pcr_ctrl_state_t state_reg;
  pcr_ctrl_state_t state_next;

  pcr_req_t  req_w;
  logic      wr_take_w;
  logic      rd_take_w;
  logic      hit_pad_w;
  logic      hit_soft_w;
  logic      hit_synth_w;
  logic [2:0] pad_idx_w;
  logic [2:0] synth_idx_w;
  logic      soft_run_w;
  logic      soft_run_next_w;
  pcr_word_t synth_rdata_w;
  pcr_word_t local_rdata_w;
  pcr_word_t soft_next_w;

  pcr_word_t [`PCR_PAD_COUNT-1:0]    pad_next_w;
  pcr_pad_bus_t                      fields_next_w;

  // Gather the port request into one carrier.
  assign req_w.wr    = reg_wr_in;
  assign req_w.rd    = reg_rd_in;
  assign req_w.addr  = reg_addr_in;
  assign req_w.wdata = reg_wdata_in;

  // A write in the same cycle as a read wins; that read is dropped.
  assign wr_take_w = req_w.wr;
  assign rd_take_w = req_w.rd && !req_w.wr;

  // Address decode.
  assign hit_pad_w   = (req_w.addr >= PAD_BASE) &&
                       (req_w.addr <= PAD_LAST);
  assign hit_soft_w  = (req_w.addr == `PCR_ADDR_SOFT_RESET);
  assign hit_synth_w = (req_w.addr >= `PCR_ADDR_SYNTH_FIRST) &&
                       (req_w.addr <= `PCR_ADDR_SYNTH_LAST);

  assign pad_idx_w   = 3'(req_w.addr - PAD_BASE);
  assign synth_idx_w = 3'(req_w.addr - `PCR_ADDR_SYNTH_FIRST);

  // Soft reset register; it is itself never cleared by the soft reset.
  assign soft_next_w = (wr_take_w && hit_soft_w) ? req_w.wdata
                                                 : state_reg.soft_word;

  // Bit 0 is active low: zero holds the soft reset state.
  assign soft_run_w      = state_reg.soft_word[`PCR_SOFT_RUN_BIT];
  assign soft_run_next_w = soft_next_w[`PCR_SOFT_RUN_BIT];

  // Clock-synthesis registers stay writable and readable while the soft
  // reset is active, and the soft reset is not wired to them.
  pcr_synth_regs u_synth_regs (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .wr_en_in    (wr_take_w && hit_synth_w),
    .wr_idx_in   (synth_idx_w),
    .wr_data_in  (req_w.wdata),
    .rd_en_in    (rd_take_w && hit_synth_w),
    .rd_idx_in   (synth_idx_w),
    .rd_data_out (synth_rdata_w)
  );

  // Per-pad storage and field extraction.
  genvar gi;
  generate
    for (gi = 0; gi < `PCR_PAD_COUNT; gi++) begin : g_pad
      pcr_word_t word_w;

      // While soft reset is held, each pad returns to its default and
      // writes to it are dropped, as under a hardware reset.
      always_comb begin
        word_w = state_reg.pad[gi];
        if (wr_take_w && hit_pad_w && pad_idx_w == 3'(gi)) begin
          word_w = req_w.wdata;
        end
        if (!soft_run_w) begin
          word_w = PAD_RESET[gi];
        end
      end

      assign pad_next_w[gi] = word_w;

      // Reserved bits are stored but steer nothing.
      assign fields_next_w[gi].pull_en =
        word_w[`PCR_PULL_BIT];
      assign fields_next_w[gi].edge_rate =
        pcr_edge_rate_t'(word_w[`PCR_EDGE_HI:`PCR_EDGE_LO]);
      assign fields_next_w[gi].drive_level =
        pcr_drive_level_t'(word_w[`PCR_DRIVE_HI:`PCR_DRIVE_LO]);
    end
  endgenerate

  // Read value of the local registers.
  always_comb begin
    local_rdata_w = '0;
    if (hit_pad_w) begin
      local_rdata_w = state_reg.pad[pad_idx_w];
    end else if (hit_soft_w) begin
      local_rdata_w = state_reg.soft_word;
    end
  end

  always_comb begin
    state_next = state_reg;

    state_next.pad        = pad_next_w;
    state_next.pad_fields = fields_next_w;
    state_next.soft_word  = soft_next_w;

    // Soft reset state follows the active-low control bit.
    unique case (state_reg.fsm)
      PCR_ST_RUN: begin
        if (!soft_run_next_w) begin
          state_next.fsm = PCR_ST_SOFT;
        end
      end
      PCR_ST_SOFT: begin
        if (soft_run_next_w) begin
          state_next.fsm = PCR_ST_RUN;
        end
      end
      default: begin
        state_next.fsm = PCR_ST_RUN;
      end
    endcase

    // Once the port has switched to SPI it stays there; only the
    // hardware reset clears this flag.
    if (spi_select_in) begin
      state_next.spi_mode = 1'b1;
    end

    // First read stage: decode and capture local data.
    state_next.rd_stage_vld = rd_take_w;
    state_next.rd_stage     = local_rdata_w;
    if (!rd_take_w) begin
      state_next.rd_src = PCR_SRC_NONE;
    end else if (hit_synth_w) begin
      state_next.rd_src = PCR_SRC_SYNTH;
    end else if (hit_pad_w || hit_soft_w) begin
      state_next.rd_src = PCR_SRC_LOCAL;
    end else begin
      state_next.rd_src = PCR_SRC_NONE;
    end

    // Second read stage: answer, unmapped addresses read as zero.
    state_next.rd_valid = state_reg.rd_stage_vld;
    unique case (state_reg.rd_src)
      PCR_SRC_NONE:  state_next.rdata = '0;
      PCR_SRC_LOCAL: state_next.rdata = state_reg.rd_stage;
      PCR_SRC_SYNTH: state_next.rdata = synth_rdata_w;
      default:       state_next.rdata = '0;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg.fsm          <= PCR_ST_RUN;
      state_reg.pad          <= PAD_RESET;
      state_reg.soft_word    <= `PCR_RST_SOFT_RESET;
      state_reg.spi_mode     <= 1'b0;
      state_reg.rd_src       <= PCR_SRC_NONE;
      state_reg.rd_stage     <= '0;
      state_reg.rd_stage_vld <= 1'b0;
      state_reg.rdata        <= '0;
      state_reg.rd_valid     <= 1'b0;
      for (int i = 0; i < `PCR_PAD_COUNT; i++) begin
        state_reg.pad_fields[i].pull_en     <= PAD_RESET[i][`PCR_PULL_BIT];
        state_reg.pad_fields[i].edge_rate   <= pcr_edge_rate_t'(
          PAD_RESET[i][`PCR_EDGE_HI:`PCR_EDGE_LO]);
        state_reg.pad_fields[i].drive_level <= pcr_drive_level_t'(
          PAD_RESET[i][`PCR_DRIVE_HI:`PCR_DRIVE_LO]);
      end
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_out         = state_reg.rdata;
  assign reg_rd_valid_out      = state_reg.rd_valid;
  assign pad_cfg_out           = state_reg.pad_fields;
  assign soft_reset_active_out = state_reg.fsm[1];
  assign control_port_spi_out  = state_reg.spi_mode;

endmodule

`default_nettype wire

// ### bench/pcr_pad_ctrl_sva.sv
`default_nettype none

module pcr_pad_ctrl_chk
  import pcr_pkg::*;
(
  input wire logic         core_clk_in,
  input wire logic         arst_n_in,
  input wire logic         reg_wr_in,
  input wire logic         reg_rd_in,
  input wire pcr_word_t    reg_addr_in,
  input wire pcr_word_t    reg_wdata_in,
  input wire logic         spi_select_in,
  input wire pcr_word_t    reg_rdata_out,
  input wire logic         reg_rd_valid_out,
  input wire pcr_pad_bus_t pad_cfg_out,
  input wire logic         soft_reset_active_out,
  input wire logic         control_port_spi_out
);
  localparam pcr_pad_bus_t PadDefault = {5'h08, {4{5'h18}}};
  wire logic       rd_take = reg_rd_in && !reg_wr_in;
  wire logic       soft_wr = reg_wr_in && reg_addr_in == 16'hf890;
  wire logic [4:0] wfield  = reg_wdata_in[4:0];

  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_read_answer_lat: assert property (
    rd_take |-> ##2 reg_rd_valid_out)
    else $error("read answer not two cycles after request");
  a_valid_has_cause: assert property (
    reg_rd_valid_out |-> $past(rd_take, 2))
    else $error("read valid without a taken read");
  a_soft_enter: assert property (
    soft_wr && !reg_wdata_in[0] |=> soft_reset_active_out)
    else $error("soft reset not entered");
  a_soft_leave: assert property (
    soft_wr && reg_wdata_in[0] |=> !soft_reset_active_out)
    else $error("soft reset not released");
  a_soft_pad_defaults: assert property (
    soft_reset_active_out [*2] |=> pad_cfg_out == PadDefault)
    else $error("pads not at defaults during soft reset");
  a_pad_write_lands: assert property (
    !soft_reset_active_out && reg_wr_in && reg_addr_in == 16'hf7a0
    |=> pad_cfg_out[1] == $past(wfield))
    else $error("pad write not presented to pad");
  a_pad_idle_hold: assert property (
    !reg_wr_in && !soft_reset_active_out |=> $stable(pad_cfg_out))
    else $error("pad settings changed without a write");
  a_spi_mode_set: assert property (
    spi_select_in |=> control_port_spi_out)
    else $error("spi mode not taken");
  a_spi_mode_sticky: assert property (
    control_port_spi_out |=> control_port_spi_out)
    else $error("spi mode dropped without hardware reset");

  c_soft_held: cover property (soft_reset_active_out [*2]);
  c_read_done: cover property (reg_rd_valid_out);
  c_spi_on: cover property ($rose(control_port_spi_out));
endmodule

bind pcr_pad_ctrl pcr_pad_ctrl_chk u_chk (.core_clk_in, .arst_n_in, .reg_wr_in,
  .reg_rd_in, .reg_addr_in, .reg_wdata_in, .spi_select_in, .reg_rdata_out,
  .reg_rd_valid_out, .pad_cfg_out, .soft_reset_active_out,
  .control_port_spi_out);

`default_nettype wire

// ### bench/pcr_host_model.sv
`default_nettype none

module pcr_host_model
  import pcr_pkg::*;
(
  input  wire logic      core_clk_in,
  input  wire pcr_word_t rdata_in,
  input  wire logic      rd_valid_in,
  output logic           wr_out,
  output logic           rd_out,
  output pcr_word_t      addr_out,
  output pcr_word_t      wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
  end

  // Callers pass zeros in reserved bits.
  // Idle lines show inverted values so a stale address cannot match.
  task automatic write_word(input pcr_word_t a, input pcr_word_t d);
    @(negedge core_clk_in);
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(negedge core_clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask

  task automatic read_word(input pcr_word_t a, output pcr_word_t d,
                           output logic v);
    @(negedge core_clk_in);
    rd_out = 1'b1;
    addr_out = a;
    @(negedge core_clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    // The answer stands for one cycle, from the first edge after the taking edge.
    @(negedge core_clk_in);
    v = rd_valid_in;
    d = rdata_in;
  endtask
endmodule

`default_nettype wire

// ### bench/testbench.sv
`default_nettype none

module testbench
  import pcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam pcr_word_t PAD_ADDR [5] = '{16'hf79f, 16'hf7a0, 16'hf7a1,
                                         16'hf7a2, 16'hf7a3};
  localparam pcr_word_t PAD_RST [5] = '{16'h0018, 16'h0018, 16'h0018,
                                        16'h0018, 16'h0008};
  logic         core_clk_in = 1'b0;
  logic         arst_n_in = 1'b0;
  logic         spi_select_in = 1'b0;
  logic         reg_wr, reg_rd, rd_valid, soft_act, spi_out;
  pcr_word_t    reg_addr, reg_wdata, rdata;
  pcr_pad_bus_t pads;
  int           failures = 0;
  int           comparisons = 0;
  int           cycles = 0;

  always #20 core_clk_in = ~core_clk_in;

  pcr_pad_ctrl u_pcr_pad_ctrl (.core_clk_in, .arst_n_in, .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .spi_select_in, .reg_rdata_out(rdata), .reg_rd_valid_out(rd_valid),
    .pad_cfg_out(pads), .soft_reset_active_out(soft_act),
    .control_port_spi_out(spi_out));
  pcr_host_model u_host (.core_clk_in, .rdata_in(rdata),
    .rd_valid_in(rd_valid), .wr_out(reg_wr), .rd_out(reg_rd),
    .addr_out(reg_addr), .wdata_out(reg_wdata));

  task automatic check(input string what, input pcr_word_t seen,
                       input pcr_word_t exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input pcr_word_t a, input pcr_word_t exp);
    pcr_word_t d;
    logic v;
    u_host.read_word(a, d, v);
    check("read valid", {15'h0, v}, 16'h0001);
    check("read data", d, exp);
  endtask

  task automatic pads_default;
    for (int i = 0; i < 5; i++) begin
      check("pad default", {11'h0, pads[i]}, PAD_RST[i]);
    end
  endtask

  task automatic t_reset_values;
    for (int i = 0; i < 5; i++) begin
      rd_chk(PAD_ADDR[i], PAD_RST[i]);
      check("pad out", {11'h0, pads[i]}, PAD_RST[i]);
    end
    rd_chk(16'hf890, 16'h0001);
    rd_chk(16'h0100, 16'h0000);
    check("soft flag", {15'h0, soft_act}, 16'h0000);
    $display("reset values done");
  endtask

  task automatic t_fields;
    pcr_word_t w;
    for (int p = 0; p < 5; p++) begin
      for (int k = 0; k < 4; k++) begin
        w = {11'h0, k[0], k[1:0], ~k[1:0]};
        u_host.write_word(PAD_ADDR[p], w);
        check("pad fields", {11'h0, pads[p]}, w);
        rd_chk(PAD_ADDR[p], w);
      end
    end
    $display("pad fields done");
  endtask

  task automatic t_soft_reset;
    u_host.write_word(16'hf003, 16'h00a5);
    @(negedge core_clk_in);
    spi_select_in = 1'b1;
    @(negedge core_clk_in);
    spi_select_in = 1'b0;
    u_host.write_word(16'hf7a1, 16'h0007);
    u_host.write_word(16'hf890, 16'h0000);
    repeat (2) @(negedge core_clk_in);
    check("soft flag", {15'h0, soft_act}, 16'h0001);
    pads_default();
    u_host.write_word(16'hf7a2, 16'h0003);
    check("pad blocked", {11'h0, pads[3]}, 16'h0018);
    u_host.write_word(16'hf005, 16'h005a);
    rd_chk(16'hf005, 16'h005a);
    rd_chk(16'hf003, 16'h00a5);
    check("spi mode", {15'h0, spi_out}, 16'h0001);
    u_host.write_word(16'hf890, 16'h0001);
    check("soft flag", {15'h0, soft_act}, 16'h0000);
    check("spi mode", {15'h0, spi_out}, 16'h0001);
    u_host.write_word(16'hf7a2, 16'h0003);
    check("pad after", {11'h0, pads[3]}, 16'h0003);
    $display("soft reset done");
  endtask

  task automatic t_hw_reset;
    @(negedge core_clk_in);
    arst_n_in = 1'b0;
    @(negedge core_clk_in);
    arst_n_in = 1'b1;
    check("spi mode", {15'h0, spi_out}, 16'h0000);
    pads_default();
    rd_chk(16'hf003, 16'h0000);
    $display("hardware reset done");
  endtask

  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    repeat (4) @(negedge core_clk_in);
    arst_n_in = 1'b1;
    t_reset_values();
    t_fields();
    t_soft_reset();
    t_hw_reset();
    close_out();
  end
endmodule

`default_nettype wire
